// ===== hdl/osc_calib_pkg.sv
/*
 * constants for the oscillator calibration counter: register indices,
 * field positions, reset values, interrupt layout.
 * assumes an apb slave with 32-bit data, one register per aligned word.
 */
package osc_calib_pkg;

    // ----------------------------------------------------------------
    // register indices (printed offsets are half-word apart)
    // ----------------------------------------------------------------
    localparam logic [31:0] CALIB_CONTROL_IDX       = 32'h5000_1600;
    localparam logic [31:0] CALIB_WINDOW_LENGTH_IDX = 32'h5000_1602;
    localparam logic [31:0] CALIB_RESULT_LOW_IDX    = 32'h5000_1604;
    localparam logic [31:0] CALIB_RESULT_HIGH_IDX   = 32'h5000_1606;
    localparam logic [31:0] CALIB_IRQ_STATUS_IDX    = 32'h5000_1608;
    localparam logic [31:0] CALIB_IRQ_MASK_IDX      = 32'h5000_160A;

    // byte address is four times the index; only low 16 bits decoded
    localparam logic [15:0] ADDR_CONTROL   = 16'h5800;
    localparam logic [15:0] ADDR_WINDOW    = 16'h5808;
    localparam logic [15:0] ADDR_RES_LOW   = 16'h5810;
    localparam logic [15:0] ADDR_RES_HIGH  = 16'h5818;
    localparam logic [15:0] ADDR_IRQ_STAT  = 16'h5820;
    localparam logic [15:0] ADDR_IRQ_MASK  = 16'h5828;

    // ----------------------------------------------------------------
    // fields
    // ----------------------------------------------------------------
    localparam int          START_BIT      = 2;
    localparam int          SEL_LSB        = 0;
    localparam int          SEL_W          = 2;
    localparam logic [15:0] CONTROL_RESET  = 16'h0000;
    localparam logic [15:0] WINDOW_RESET   = 16'h0000;
    localparam logic [31:0] RESULT_RESET   = 32'h0000_0000;
    localparam logic [15:0] WINDOW_ONE     = 16'h0001;
    localparam logic [31:0] TALLY_ONE      = 32'h0000_0001;
    localparam logic [31:0] PSLVERR_NONE   = 32'h0000_0000;

    // interrupt status: bit 0 = measurement done
    localparam int          IRQ_DONE_BIT   = 0;
    localparam logic [0:0]  IRQ_RESET      = 1'b0;

    // source select codes
    localparam logic [1:0] SRC_SLOW_RC     = 2'h0;
    localparam logic [1:0] SRC_FAST_RC     = 2'h1;
    localparam logic [1:0] SRC_SLOW_XTAL   = 2'h2;
    localparam logic [1:0] SRC_SLOW_RCX    = 2'h3;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_ALIGN = 3'b010,
        ST_COUNT = 3'b100
    } calib_state_type;

endpackage : osc_calib_pkg

// ===== hdl/osc_calib_counter.sv
/*
 * oscillator calibration counter: apb register file, source selection,
 * edge synchroniser, window down-counter and 32-bit crystal tally.
 * assumes pclk is the 16 MHz-class fast crystal clock domain and the
 * four oscillator inputs are free-running and asynchronous to it.
 */
// Operation
// - writing one to start begins measurement
// - start self-clears when done; tally valid
// - two-bit field selects measured oscillator
// - window counts down to one, source cycles
// - low result holds tally bits 15:0
// - high result holds tally bits 31:16
`timescale 1ns/1ps
`default_nettype none

module osc_calib_counter
    import osc_calib_pkg::*;
(
    // apb
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    // oscillators under measurement
    input  wire logic        slow_rc_osc,
    input  wire logic        fast_rc_osc,
    input  wire logic        slow_crystal_osc,
    input  wire logic        slow_rcx_osc,
    // interrupt
    output var  logic        irq
);

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    function automatic logic hit(input logic [31:0] a, input logic [15:0] off);
        hit = (a[15:0] == off);
    endfunction : hit

    logic access;
    logic wr;
    logic rd;
    logic mapped;
    assign access = psel & penable;
    // a write lands only at the edge where pready is seen high
    assign wr     = access & pwrite & pready;
    assign rd     = access & ~pwrite;
    assign mapped = hit(paddr, ADDR_CONTROL) | hit(paddr, ADDR_WINDOW)
                  | hit(paddr, ADDR_RES_LOW) | hit(paddr, ADDR_RES_HIGH)
                  | hit(paddr, ADDR_IRQ_STAT) | hit(paddr, ADDR_IRQ_MASK);

    // ----------------------------------------------------------------
    // source select and synchroniser
    // ----------------------------------------------------------------
    logic [3:0] osc_raw;
    logic [3:0] sync1_q;
    logic [3:0] sync2_q;
    logic [3:0] sync3_q;
    assign osc_raw = {slow_rcx_osc, slow_crystal_osc, fast_rc_osc, slow_rc_osc};

    // every source synchronised; selection happens after, so a select
    // change never feeds a glitch into the first flop
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_sync
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sync1_q[g] <= 1'b0;
                    sync2_q[g] <= 1'b0;
                    sync3_q[g] <= 1'b0;
                end else begin
                    sync1_q[g] <= osc_raw[g];
                    sync2_q[g] <= sync1_q[g];
                    sync3_q[g] <= sync2_q[g];
                end
            end
        end
    endgenerate

    logic [1:0] sel;
    logic       src_rise;
    // limitation: the fast rc source near pclk rate will alias; it is
    // resolved only when its frequency is below half of pclk
    assign src_rise = sync2_q[sel] & ~sync3_q[sel];

    // ----------------------------------------------------------------
    // registers and measurement
    // ----------------------------------------------------------------
    logic            start_q,  start_d;
    logic [1:0]      sel_q,    sel_d;
    logic [15:0]     window_q, window_d;
    logic [15:0]     remain_q, remain_d;
    logic [31:0]     tally_q,  tally_d;
    logic [31:0]     result_q, result_d;
    logic            stat_q,   stat_d;
    logic            mask_q,   mask_d;
    calib_state_type state_q,  state_d;
    logic [31:0]     prdata_d;
    logic            pready_d;
    logic            pslverr_d;
    logic            irq_d;

    assign sel = sel_q;

    always_comb begin
        logic done;
        done      = 1'b0;
        start_d   = start_q;
        sel_d     = sel_q;
        window_d  = window_q;
        remain_d  = remain_q;
        tally_d   = tally_q;
        result_d  = result_q;
        mask_d    = mask_q;
        state_d   = state_q;

        unique case (state_q)
            ST_IDLE: begin
            end
            // wait for first source edge so the window spans whole cycles
            ST_ALIGN: begin
                if (src_rise) begin
                    tally_d = RESULT_RESET;
                    state_d = ST_COUNT;
                    if (remain_q <= WINDOW_ONE) begin
                        done = 1'b1;
                    end
                end
            end
            ST_COUNT: begin
                tally_d = tally_q + TALLY_ONE;
                if (src_rise) begin
                    remain_d = remain_q - WINDOW_ONE;
                    if (remain_q <= WINDOW_ONE + WINDOW_ONE) begin
                        done = 1'b1;
                    end
                end
            end
        endcase

        if (done) begin
            state_d  = ST_IDLE;
            start_d  = 1'b0;
            result_d = (state_q == ST_COUNT) ? tally_q + TALLY_ONE : RESULT_RESET;
        end

        if (wr && hit(paddr, ADDR_CONTROL) && pstrb[0]) begin
            sel_d = pwdata[SEL_LSB +: SEL_W];
            if (pwdata[START_BIT] && state_q == ST_IDLE) begin
                start_d  = 1'b1;
                remain_d = window_q;
                state_d  = ST_ALIGN;
            end
        end
        if (wr && hit(paddr, ADDR_WINDOW)) begin
            if (pstrb[0]) window_d[7:0]  = pwdata[7:0];
            if (pstrb[1]) window_d[15:8] = pwdata[15:8];
        end
        if (wr && hit(paddr, ADDR_IRQ_MASK) && pstrb[0]) begin
            mask_d = pwdata[IRQ_DONE_BIT];
        end

        // set wins over a write-one clear in the same cycle
        stat_d = stat_q;
        if (wr && hit(paddr, ADDR_IRQ_STAT) && pstrb[0] && pwdata[IRQ_DONE_BIT]) begin
            stat_d = 1'b0;
        end
        if (done) begin
            stat_d = 1'b1;
        end
        irq_d = stat_d & mask_d;

        prdata_d  = PSLVERR_NONE;
        // one wait state: data is built in the first access cycle and
        // stands together with pready in the second
        pready_d  = access & ~pready;
        pslverr_d = access & ~pready & ~mapped;
        if (rd) begin
            if (hit(paddr, ADDR_CONTROL)) begin
                prdata_d[START_BIT]          = start_q;
                prdata_d[SEL_LSB +: SEL_W]   = sel_q;
            end
            if (hit(paddr, ADDR_WINDOW))   prdata_d[15:0] = window_q;
            if (hit(paddr, ADDR_RES_LOW))  prdata_d[15:0] = result_q[15:0];
            if (hit(paddr, ADDR_RES_HIGH)) prdata_d[15:0] = result_q[31:16];
            if (hit(paddr, ADDR_IRQ_STAT)) prdata_d[IRQ_DONE_BIT] = stat_q;
            if (hit(paddr, ADDR_IRQ_MASK)) prdata_d[IRQ_DONE_BIT] = mask_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_q  <= CONTROL_RESET[START_BIT];
            sel_q    <= CONTROL_RESET[SEL_LSB +: SEL_W];
            window_q <= WINDOW_RESET;
            remain_q <= WINDOW_RESET;
            tally_q  <= RESULT_RESET;
            result_q <= RESULT_RESET;
            stat_q   <= IRQ_RESET;
            mask_q   <= IRQ_RESET;
            state_q  <= ST_IDLE;
            prdata   <= PSLVERR_NONE;
            pready   <= 1'b0;
            pslverr  <= 1'b0;
            irq      <= 1'b0;
        end else begin
            start_q  <= start_d;
            sel_q    <= sel_d;
            window_q <= window_d;
            remain_q <= remain_d;
            tally_q  <= tally_d;
            result_q <= result_d;
            stat_q   <= stat_d;
            mask_q   <= mask_d;
            state_q  <= state_d;
            prdata   <= prdata_d;
            pready   <= pready_d;
            pslverr  <= pslverr_d;
            irq      <= irq_d;
        end
    end

endmodule : osc_calib_counter

`default_nettype wire

// ===== verification/osc_calib_checker.sv
/* apb and read-data checks for osc_calib_counter.
   assumes one pclk domain and a bind from the bench top. */
`timescale 1ns/1ps
`default_nettype none
module osc_calib_checker
    import osc_calib_pkg::*;
(
    // apb
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // oscillators and interrupt
    input wire logic        slow_rc_osc,
    input wire logic        fast_rc_osc,
    input wire logic        slow_crystal_osc,
    input wire logic        slow_rcx_osc,
    input wire logic        irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic mapped;
    logic first;
    assign mapped = paddr[15:0] inside {ADDR_CONTROL, ADDR_WINDOW, ADDR_RES_LOW,
                                        ADDR_RES_HIGH, ADDR_IRQ_STAT, ADDR_IRQ_MASK};
    assign first = psel && penable && !pready;
    a_ready_one_wait: assert property (first |=> pready) else $error("no answer");
    a_ready_pulse: assert property (pready |=> !pready) else $error("long ready");
    a_ready_cause: assert property (pready |-> $past(first)) else $error("stray ready");
    a_err_unmapped: assert property (first && !mapped |=> pslverr) else $error("no err");
    a_err_mapped: assert property (first && mapped |=> !pslverr) else $error("bad err");
    a_err_data_zero: assert property (pslverr && !pwrite |-> prdata == PSLVERR_NONE)
        else $error("err data");
    a_upper_half_zero: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0000)
        else $error("upper bits");
    a_control_reserved: assert property (pready && !pwrite && paddr[15:0] == ADDR_CONTROL
        |-> prdata[15:3] == 13'h0000) else $error("control bits");
    c_error: cover property (pready && pslverr);
    c_high_half: cover property (pready && paddr[15:0] == ADDR_RES_HIGH && prdata[0]);
    c_irq_fall: cover property ($fell(irq));
endmodule : osc_calib_checker
`default_nettype wire

// ===== verification/osc_calib_counter_tb_top.sv
/* self-checking bench for osc_calib_counter over apb.
   assumes the design package is compiled first; oscillators come from pclk. */
`timescale 1ns/1ps
`default_nettype none
module osc_calib_counter_tb_top
    import osc_calib_pkg::*;
;
    localparam int per [4] = '{10, 6, 14, 8};
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, irq, pready, pslverr;
    logic [31:0] paddr = 0, pwdata = 0, prdata;
    logic [3:0]  pstrb = 4'hf;
    logic        slow_rc_osc = 0, fast_rc_osc = 0, slow_crystal_osc = 0, slow_rcx_osc = 0;
    int          tick = 0, n_fail = 0, total_checks = 0;
    osc_calib_counter osc_calib_counter_inst (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .slow_rc_osc, .fast_rc_osc,
        .slow_crystal_osc, .slow_rcx_osc, .irq);
    initial forever #2 pclk = ~pclk;
    // free-running sources, each well below pclk/2
    always @(posedge pclk) begin
        tick             <= tick + 1;
        slow_rc_osc      <= (tick % per[0]) < per[0] / 2;
        fast_rc_osc      <= (tick % per[1]) < per[1] / 2;
        slow_crystal_osc <= (tick % per[2]) < per[2] / 2;
        slow_rcx_osc     <= (tick % per[3]) < per[3] / 2;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // pready, prdata and pslverr are taken at the rising edge itself
    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic er);
        logic ok;
        ok = 1'b0;
        @(posedge pclk);
        psel    <= 1;
        pwrite  <= w;
        paddr   <= {16'h0000, a};
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1;
        for (int n = 0; n < 20 && !ok; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) ok = 1'b1;
        end
        rd = prdata;
        er = pslverr;
        if (!ok) begin
            n_fail++;
            $display("unexpected at %0t: no pready", $time);
        end
        psel    <= 0;
        penable <= 0;
    endtask : apb
    task automatic wr(input logic [15:0] a, input logic [31:0] wd);
        logic [31:0] d;
        logic        e;
        apb(1, a, wd, d, e);
    endtask : wr
    task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic        e;
        apb(0, a, 32'h0000_0000, d, e);
        chk(d, exp);
    endtask : rd_chk
    task automatic t_regs();
        logic [15:0] map [6] = '{ADDR_CONTROL, ADDR_WINDOW, ADDR_RES_LOW, ADDR_RES_HIGH,
                                 ADDR_IRQ_STAT, ADDR_IRQ_MASK};
        logic [31:0] d;
        logic        e;
        foreach (map[i]) rd_chk(map[i], 32'h0000_0000);
        wr(ADDR_RES_LOW, 32'hffff_ffff);
        rd_chk(ADDR_RES_LOW, 32'h0000_0000);
        wr(ADDR_WINDOW, 32'h0000_a5a5);
        rd_chk(ADDR_WINDOW, 32'h0000_a5a5);
        apb(0, 16'h5804, 32'h0000_0000, d, e);
        chk(d, 32'h0000_0000);
        chk({31'h0, e}, 32'h0000_0001);
        $display("test registers done");
    endtask : t_regs
    task automatic t_measure(input logic [1:0] s, input logic [15:0] w, input logic m);
        logic [31:0] d;
        logic [31:0] ex;
        logic        e;
        ex = 32'((int'(w) - 1) * per[s]);
        wr(ADDR_IRQ_MASK, {31'h0, m});
        wr(ADDR_WINDOW, {16'h0000, w});
        wr(ADDR_CONTROL, {29'h0, 1'b1, s});
        apb(0, ADDR_CONTROL, 32'h0000_0000, d, e);
        chk(d, {29'h0, 1'b1, s});
        for (int n = 0; n < 30000 && d[START_BIT] !== 1'b0; n++)
            apb(0, ADDR_CONTROL, 32'h0000_0000, d, e);
        chk(d, {30'h0, s});
        rd_chk(ADDR_RES_LOW, {16'h0000, ex[15:0]});
        rd_chk(ADDR_RES_HIGH, {16'h0000, ex[31:16]});
        rd_chk(ADDR_IRQ_STAT, 32'h0000_0001);
        @(negedge pclk);
        chk({31'h0, irq}, {31'h0, m});
        wr(ADDR_IRQ_STAT, 32'h0000_0001);
        rd_chk(ADDR_IRQ_STAT, 32'h0000_0000);
        @(negedge pclk);
        chk({31'h0, irq}, 32'h0000_0000);
        $display("test measure source %0d done", s);
    endtask : t_measure
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : give_verdict
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1;
        t_regs();
        t_measure(2'h0, 16'h0002, 1'b1);
        t_measure(2'h1, 16'h012c, 1'b0);
        t_measure(2'h3, 16'h0003, 1'b1);
        t_measure(2'h2, 16'h1388, 1'b1);
        give_verdict();
    end
    // cut a hang at about a quarter past the expected run length
    initial begin
        #360000;
        n_fail++;
        give_verdict();
    end
endmodule : osc_calib_counter_tb_top
bind osc_calib_counter osc_calib_checker osc_calib_checker_inst (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .slow_rc_osc,
    .fast_rc_osc, .slow_crystal_osc, .slow_rcx_osc, .irq);
`default_nettype wire
